// ### adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// register addresses
`define A_MODE 6'h00
`define A_STATUS 6'h01
`define A_ENABLE 6'h02
`define A_CONV_ZERO 6'h03
`define A_CONV_FS 6'h04
`define G_SETUP 3'h2
`define G_DATA 3'h3
`define G_CHSTAT 3'h4
`define G_CH_ZERO 3'h5
`define G_CH_FS 3'h6
// mode register fields
`define F_OP 2:0
`define F_SEL 5:3
`define F_CLAMP 6
`define F_SYNC 7
// setup register fields
`define F_FW 6:0
`define F_CHOP 7
`define F_BIP 8
// reset values
`define FW_RST 7'h11
`define CONV_FS_RST 24'h200000
`define CH_FS_RST 24'h200000
// phase lengths in master clock cycles
`define SETTLE1_SHORT 16'd43
`define SETTLE1_LONG 16'd44
`define SETTLE2_LEN 16'd42
`define SCALE_LEN 16'd163
`define SAMPLE_SHIFT 4
// scaling constants
`define UNI_SHIFT 21
`define BIP_SHIFT 22
`define BIP_MID 24'h800000
`define CODE_MAX 24'hffffff
`define CHZ_SIGN 22
`define CHZ_MAG 21:0
`define CHZ_MAG_MAX 22'h3fffff
// full-scale calibration divider: 2^45 / span
`define DIV_BITS 6'd46
`define DIV_QTOP 6'd24
`endif

// ### adc_seq_pkg.sv
package adc_seq_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_SINGLE = 3'h1,
    MODE_CONT = 3'h2,
    MODE_SELF_ZERO = 3'h4,
    MODE_SYS_ZERO = 3'h6,
    MODE_SYS_FS = 3'h7
  } mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_GATE = 3'h1,
    ST_SETTLE1 = 3'h2,
    ST_SAMPLE1 = 3'h3,
    ST_SETTLE2 = 3'h4,
    ST_SAMPLE2 = 3'h5,
    ST_SCALE = 3'h6
  } state_e;
  typedef struct packed {
    logic bipolar;
    logic chop;
    logic [6:0] fw;
  } chan_setup_s;
  typedef struct packed {
    logic [23:0] data;
    logic sign;
    logic overrange_flag;
  } result_s;
endpackage : adc_seq_pkg

// ### result_scaler.sv
`include "adc_seq_cfg.svh"
module result_scaler import adc_seq_pkg::*; (
  // operands
  input wire logic [23:0] raw_in,
  input wire logic [23:0] conv_zero_in,
  input wire logic [23:0] conv_fs_in,
  input wire logic [23:0] ch_zero_in,
  input wire logic [23:0] ch_fs_in,
  input wire logic bipolar_in,
  input wire logic clamp_in,
  // results
  output result_s result_out,
  output logic [23:0] ch_zero_cal_out,
  output logic signed [25:0] span_out
);
  logic signed [63:0] d1, p1, st1, chz, d2, p2, v, off, mag;

  // two-stage calibration and range coding
  always_comb begin
    d1 = $signed({40'h0, raw_in}) - $signed({40'h0, conv_zero_in});
    p1 = d1 * $signed({40'h0, conv_fs_in});
    if (bipolar_in) begin
      st1 = (p1 >>> `BIP_SHIFT) + $signed({40'h0, `BIP_MID});
    end else begin
      st1 = p1 >>> `UNI_SHIFT;
    end
    chz = $signed({42'h0, ch_zero_in[`CHZ_MAG]});
    if (ch_zero_in[`CHZ_SIGN]) begin
      chz = -chz;
    end
    d2 = st1 - chz;
    p2 = d2 * $signed({40'h0, ch_fs_in});
    v = p2 >>> `UNI_SHIFT;
    result_out.overrange_flag = (v < 0) || (v > $signed({40'h0, `CODE_MAX}));
    result_out.sign = bipolar_in ? (v < $signed({40'h0, `BIP_MID})) : (v < 0);
    if (clamp_in && result_out.overrange_flag) begin
      result_out.data = (v < 0) ? 24'h0 : `CODE_MAX;
    end else if (!bipolar_in && v < 0) begin
      result_out.data = 24'h0;
    end else begin
      result_out.data = v[23:0];
    end
    off = bipolar_in ? st1 - $signed({40'h0, `BIP_MID}) : st1;
    mag = (off < 0) ? -off : off;
    ch_zero_cal_out = {1'b0, off < 0, (mag > $signed({42'h0, `CHZ_MAG_MAX})) ? `CHZ_MAG_MAX : mag[21:0]};
    span_out = d2[25:0];
  end
endmodule : result_scaler

// ### adc_conversion_sequencer.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer import adc_seq_pkg::*; (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [5:0] addr_in,
  input wire logic [23:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [23:0] rd_data_out,
  // analog front end
  input wire logic [23:0] filter_result_in,
  input wire logic ref_ok_in,
  input wire logic start_gate_or_gpio_pin_in,
  output logic mod_clk_out,
  output logic [2:0] mux_channel_out,
  output logic chop_reverse_out,
  output logic inputs_shorted_out,
  output logic sampling_out,
  // ready pin
  output logic rdy_n_out
);
  state_e state_reg, prev_state_reg;
  mode_e op_reg;
  logic [2:0] chan_reg;
  logic [2:0] sel_reg;
  logic clamp_reg, sync_en_reg;
  logic [7:0] enable_reg, ready_reg, ready_next, rdy_set, rdy_clr;
  chan_setup_s setup_reg [8];
  result_s data_reg [8];
  logic [7:0] reference_missing_flag_flag_reg;
  logic [23:0] ch_zero_reg [8];
  logic [23:0] ch_fs_reg [8];
  logic [23:0] conv_zero_reg, conv_fs_reg;
  logic [15:0] cnt_reg, run_len_reg, samp_len;
  logic [23:0] raw1_reg, raw2_reg, raw_avg;
  logic [24:0] chop_sum;
  logic reference_missing_flag_reg, mod_clk_reg, rdy_n_reg;
  logic [23:0] rd_data_reg, rd_mux;
  logic [25:0] rem_reg, rem_sh;
  logic [23:0] quo_reg;
  logic sat_reg;
  logic [5:0] div_cnt_reg;
  chan_setup_s cur;
  result_s res;
  logic [23:0] zero_cal;
  logic signed [25:0] span;
  logic wr_mode, start_scale, finish, is_cal, running, div_ge;

  // next enabled channel after the current one
  function automatic logic [2:0] next_chan(input logic [2:0] c, input logic [7:0] en);
    logic [2:0] n;
    logic found;
    n = c;
    found = 1'b0;
    for (int i = 1; i < 8; i++) begin
      if (!found && en[3'(c + 3'(i))]) begin
        n = 3'(c + 3'(i));
        found = 1'b1;
      end
    end
    return n;
  endfunction : next_chan

  // decoded events
  assign cur = setup_reg[chan_reg];
  assign wr_mode = wr_in && (addr_in == `A_MODE);
  assign is_cal = op_reg[2];
  assign running = (state_reg != ST_IDLE) && (state_reg != ST_GATE);
  assign start_scale = (cnt_reg == 16'h0) && ((state_reg == ST_SAMPLE2) || (state_reg == ST_SAMPLE1 && !cur.chop));
  assign finish = (state_reg == ST_SCALE) && (cnt_reg == 16'h0);
  assign samp_len = 16'(({9'h0, cur.fw} + 16'h1) << `SAMPLE_SHIFT) - 16'h1;
  assign chop_sum = {1'b0, raw1_reg} + {1'b0, ~raw2_reg};
  assign raw_avg = cur.chop ? chop_sum[24:1] : raw1_reg;

  // calibration arithmetic
  result_scaler u_scaler (
    .raw_in(raw_avg),
    .conv_zero_in(conv_zero_reg),
    .conv_fs_in(conv_fs_reg),
    .ch_zero_in(ch_zero_reg[chan_reg]),
    .ch_fs_in(ch_fs_reg[chan_reg]),
    .bipolar_in(cur.bipolar),
    .clamp_in(clamp_reg),
    .result_out(res),
    .ch_zero_cal_out(zero_cal),
    .span_out(span)
  );

  // mode, channel select and control bits
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_reg <= MODE_IDLE;
      sel_reg <= 3'h0;
      clamp_reg <= 1'b0;
      sync_en_reg <= 1'b0;
      enable_reg <= 8'h0;
    end else begin
      if (wr_mode) begin
        op_reg <= mode_e'(wr_data_in[`F_OP]);
        sel_reg <= wr_data_in[`F_SEL];
        clamp_reg <= wr_data_in[`F_CLAMP];
        sync_en_reg <= wr_data_in[`F_SYNC];
      end else if (finish && op_reg != MODE_CONT) begin
        op_reg <= MODE_IDLE;
      end
      if (wr_in && addr_in == `A_ENABLE) begin
        enable_reg <= wr_data_in[7:0];
      end
    end
  end

  // conversion cycle sequencer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      chan_reg <= 3'h0;
      cnt_reg <= 16'h0;
    end else if (wr_mode) begin
      chan_reg <= wr_data_in[`F_SEL];
      cnt_reg <= 16'h0;
      state_reg <= (wr_data_in[`F_OP] == MODE_IDLE) ? ST_IDLE : ST_GATE;
    end else begin
      cnt_reg <= cnt_reg - 16'h1;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 16'h0;
        end
        ST_GATE: begin
          cnt_reg <= 16'h0;
          if (!sync_en_reg || start_gate_or_gpio_pin_in) begin
            state_reg <= ST_SETTLE1;
            cnt_reg <= (mod_clk_reg ? `SETTLE1_LONG : `SETTLE1_SHORT) - 16'h1;
          end
        end
        ST_SETTLE1: begin
          if (cnt_reg == 16'h0) begin
            state_reg <= ST_SAMPLE1;
            cnt_reg <= samp_len;
          end
        end
        ST_SAMPLE1: begin
          if (cnt_reg == 16'h0) begin
            state_reg <= cur.chop ? ST_SETTLE2 : ST_SCALE;
            cnt_reg <= (cur.chop ? `SETTLE2_LEN : `SCALE_LEN) - 16'h1;
          end
        end
        ST_SETTLE2: begin
          if (cnt_reg == 16'h0) begin
            state_reg <= ST_SAMPLE2;
            cnt_reg <= samp_len;
          end
        end
        ST_SAMPLE2: begin
          if (cnt_reg == 16'h0) begin
            state_reg <= ST_SCALE;
            cnt_reg <= `SCALE_LEN - 16'h1;
          end
        end
        ST_SCALE: begin
          if (cnt_reg == 16'h0) begin
            if (op_reg == MODE_CONT) begin
              chan_reg <= next_chan(chan_reg, enable_reg);
              state_reg <= ST_GATE;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // filter results of both sampling intervals
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raw1_reg <= 24'h0;
      raw2_reg <= 24'h0;
    end else if (cnt_reg == 16'h0 && state_reg == ST_SAMPLE1) begin
      raw1_reg <= filter_result_in;
    end else if (cnt_reg == 16'h0 && state_reg == ST_SAMPLE2) begin
      raw2_reg <= filter_result_in;
    end
  end

  // reference watch over one channel cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reference_missing_flag_reg <= 1'b0;
    end else if (state_reg == ST_GATE) begin
      reference_missing_flag_reg <= 1'b0;
    end else if (running && !ref_ok_in) begin
      reference_missing_flag_reg <= 1'b1;
    end
  end

  // serial divider giving the full-scale calibration word
  assign rem_sh = {rem_reg[24:0], div_cnt_reg == `DIV_BITS};
  assign div_ge = rem_sh >= $unsigned(span);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rem_reg <= 26'h0;
      quo_reg <= 24'h0;
      sat_reg <= 1'b0;
      div_cnt_reg <= 6'h0;
    end else if (start_scale) begin
      rem_reg <= 26'h0;
      quo_reg <= 24'h0;
      sat_reg <= 1'b0; // span only settles once the raw results load at this edge
      div_cnt_reg <= `DIV_BITS;
    end else if (div_cnt_reg != 6'h0) begin
      rem_reg <= div_ge ? rem_sh - $unsigned(span) : rem_sh;
      quo_reg <= {quo_reg[22:0], div_ge};
      div_cnt_reg <= div_cnt_reg - 6'h1;
      if ((div_ge && div_cnt_reg > `DIV_QTOP) || span <= 0) begin
        sat_reg <= 1'b1;
      end
    end
  end

  // converter calibration registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_zero_reg <= 24'h0;
      conv_fs_reg <= `CONV_FS_RST;
    end else if (finish && op_reg == MODE_SELF_ZERO) begin
      conv_zero_reg <= raw_avg - (cur.bipolar ? `BIP_MID : 24'h0);
    end else if (wr_in && addr_in == `A_CONV_ZERO) begin
      conv_zero_reg <= wr_data_in;
    end else if (wr_in && addr_in == `A_CONV_FS) begin
      conv_fs_reg <= wr_data_in;
    end
  end

  // ready bit set and clear terms
  always_comb begin
    rdy_set = 8'h0;
    rdy_clr = 8'h0;
    if (finish && is_cal) begin
      rdy_set = 8'hff;
    end else if (finish) begin
      rdy_set[chan_reg] = 1'b1;
    end
    if (rd_in && addr_in[5:3] == `G_DATA) begin
      rdy_clr[addr_in[2:0]] = 1'b1;
    end
    if (wr_mode) begin
      rdy_clr = 8'hff;
    end
    ready_next = (ready_reg & ~rdy_clr) | rdy_set;
  end

  // per channel setup, result, flags and calibration storage
  for (genvar g = 0; g < 8; g++) begin : g_chan
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ready_reg[g] <= 1'b0;
        setup_reg[g] <= '{bipolar: 1'b0, chop: 1'b1, fw: `FW_RST};
        data_reg[g] <= '0;
        reference_missing_flag_flag_reg[g] <= 1'b0;
        ch_zero_reg[g] <= 24'h0;
        ch_fs_reg[g] <= `CH_FS_RST;
      end else begin
        ready_reg[g] <= ready_next[g];
        if (wr_in && addr_in == {`G_SETUP, 3'(g)}) begin
          setup_reg[g] <= chan_setup_s'(wr_data_in[8:0]);
        end
        if (finish && !is_cal && chan_reg == 3'(g)) begin
          data_reg[g] <= res;
          reference_missing_flag_flag_reg[g] <= reference_missing_flag_reg || !ref_ok_in;
        end
        if (finish && op_reg == MODE_SYS_ZERO && chan_reg == 3'(g)) begin
          ch_zero_reg[g] <= zero_cal;
        end else if (wr_in && addr_in == {`G_CH_ZERO, 3'(g)}) begin
          ch_zero_reg[g] <= wr_data_in;
        end
        if (finish && op_reg == MODE_SYS_FS && chan_reg == 3'(g)) begin
          ch_fs_reg[g] <= sat_reg ? `CODE_MAX : quo_reg;
        end else if (wr_in && addr_in == {`G_CH_FS, 3'(g)}) begin
          ch_fs_reg[g] <= wr_data_in;
        end
      end
    end
  end

  // ready pin
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_n_reg <= 1'b1;
    end else if (finish) begin
      rdy_n_reg <= 1'b0;
    end else if (start_scale || wr_mode || ready_next == 8'h0) begin
      rdy_n_reg <= 1'b1;
    end
  end

  // modulator clock and front end controls
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mod_clk_reg <= 1'b0;
      mux_channel_out <= 3'h0;
      chop_reverse_out <= 1'b0;
      inputs_shorted_out <= 1'b0;
      sampling_out <= 1'b0;
    end else begin
      mod_clk_reg <= !mod_clk_reg;
      mux_channel_out <= chan_reg;
      chop_reverse_out <= (state_reg == ST_SETTLE2) || (state_reg == ST_SAMPLE2);
      inputs_shorted_out <= running && op_reg == MODE_SELF_ZERO;
      sampling_out <= (state_reg == ST_SAMPLE1) || (state_reg == ST_SAMPLE2);
    end
  end

  // read data mux
  always_comb begin
    rd_mux = 24'h0;
    case (addr_in[5:3])
      3'h0: begin
        if (addr_in == `A_MODE) rd_mux = {16'h0, sync_en_reg, clamp_reg, sel_reg, op_reg};
        if (addr_in == `A_STATUS) rd_mux = {15'h0, state_reg != ST_IDLE, ready_reg};
        if (addr_in == `A_ENABLE) rd_mux = {16'h0, enable_reg};
        if (addr_in == `A_CONV_ZERO) rd_mux = conv_zero_reg;
        if (addr_in == `A_CONV_FS) rd_mux = conv_fs_reg;
      end
      `G_SETUP: rd_mux = {15'h0, setup_reg[addr_in[2:0]]};
      `G_DATA: rd_mux = data_reg[addr_in[2:0]].data;
      `G_CHSTAT: begin
        rd_mux = {17'h0, reference_missing_flag_flag_reg[addr_in[2:0]], data_reg[addr_in[2:0]].overrange_flag,
                  data_reg[addr_in[2:0]].sign, ready_reg[addr_in[2:0]], addr_in[2:0]};
      end
      `G_CH_ZERO: rd_mux = ch_zero_reg[addr_in[2:0]];
      `G_CH_FS: rd_mux = ch_fs_reg[addr_in[2:0]];
      default: rd_mux = 24'h0;
    endcase
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_reg <= 24'h0;
    end else begin
      rd_data_reg <= rd_in ? rd_mux : 24'h0;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign rdy_n_out = rdy_n_reg;
  assign mod_clk_out = mod_clk_reg;

  // phase length helper for checks
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_state_reg <= ST_IDLE;
      run_len_reg <= 16'h0;
    end else begin
      prev_state_reg <= state_reg;
      run_len_reg <= (state_reg != prev_state_reg || wr_mode) ? 16'h1 : run_len_reg + 16'h1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_scale_done;
    finish && !wr_mode;
  endsequence
  sequence seq_ready_shown(logic [2:0] c);
    !rdy_n_out && ready_reg[c];
  endsequence

  AST_SETTLE1_LEN: assert property (prev_state_reg == ST_SETTLE1 && state_reg == ST_SAMPLE1
    |-> run_len_reg == `SETTLE1_SHORT || run_len_reg == `SETTLE1_LONG) else $error("first settle length wrong");
  AST_SETTLE2_LEN: assert property (prev_state_reg == ST_SETTLE2 && state_reg == ST_SAMPLE2
    |-> run_len_reg == `SETTLE2_LEN && chop_reverse_out) else $error("second settle length wrong");
  AST_SCALE_LEN: assert property (prev_state_reg == ST_SCALE && state_reg != ST_SCALE && !$past(wr_mode)
    |-> run_len_reg == `SCALE_LEN) else $error("scaling length wrong");
  AST_SAMPLE_LEN: assert property (state_reg == ST_SETTLE1 && cnt_reg == 16'h0 && !wr_mode
    |=> cnt_reg == $past(samp_len) && state_reg == ST_SAMPLE1) else $error("sampling length wrong");
  AST_RDY_HIGH: assert property (start_scale && !wr_mode |=> rdy_n_out) else $error("ready pin not high");
  AST_RDY_SET: assert property (seq_scale_done and !is_cal
    |=> seq_ready_shown($past(chan_reg))) else $error("ready not shown");
  AST_CONT_NEXT: assert property (seq_scale_done and op_reg == MODE_CONT
    |=> state_reg == ST_GATE && chan_reg == next_chan($past(chan_reg), $past(enable_reg))) else $error("no next channel");
  AST_MODCLK: assert property (mod_clk_out ##1 !mod_clk_out ##1 mod_clk_out or
    !mod_clk_out ##1 mod_clk_out ##1 !mod_clk_out) else $error("modulator clock not half rate");
  AST_CLAMP: assert property (seq_scale_done and !is_cal and clamp_reg and res.overrange_flag
    |=> data_reg[$past(chan_reg)].data == 24'h0 || data_reg[$past(chan_reg)].data == `CODE_MAX) else $error("clamp failed");
  AST_REFERENCE_MISSING_FLAG: assert property (running && !ref_ok_in && state_reg != ST_SCALE |=> reference_missing_flag_reg) else $error("reference_missing_flag lost");
  AST_SYNC_HOLD: assert property (state_reg == ST_GATE && sync_en_reg && !start_gate_or_gpio_pin_in && !wr_mode
    |=> state_reg == ST_GATE) else $error("start not held by sync pin");
  AST_CAL_END: assert property (seq_scale_done and is_cal
    |=> ready_reg == 8'hff && !rdy_n_out && op_reg == MODE_IDLE && state_reg == ST_IDLE) else $error("calibration end wrong");
  AST_SHORTED: assert property (running && op_reg == MODE_SELF_ZERO && !wr_mode |=> inputs_shorted_out)
    else $error("inputs not shorted");
  AST_READ_CLR: assert property (rd_in && addr_in[5:3] == `G_DATA
    && !(finish && (is_cal || chan_reg == addr_in[2:0]))
    |=> !ready_reg[$past(addr_in[2:0])]) else $error("ready not cleared by read");
endmodule : adc_conversion_sequencer

// ### front_end_model.sv
module front_end_model (
  // front end controls
  input wire logic sampling_in,
  input wire logic reverse_in,
  input wire logic [23:0] level_in,
  // filter output
  output logic [23:0] result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] level_seen;
  // reversed input makes the filter give the complemented result
  assign level_seen = reverse_in ? ~level_in : level_in;
  // outside sampling the filter output carries no result
  assign result_out = sampling_in ? level_seen : ~level_seen;
endmodule : front_end_model

// ### adc_conversion_sequencer_tb.sv
module adc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ref_ok = 1'b1;
  logic sync = 1'b1;
  logic b;
  logic gate_mod;
  logic [5:0] addr = 6'h00;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] level = 24'h000000;
  logic [23:0] fres, rdata, rv;
  logic [2:0] mux;
  logic modclk, chrev, shorted, samp, rdy_n;
  int n_errors = 0;
  int check_count = 0;
  int n;

  // design and analog front end
  adc_conversion_sequencer uut (.mclk_in(mclk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .filter_result_in(fres), .ref_ok_in(ref_ok),
    .start_gate_or_gpio_pin_in(sync), .mod_clk_out(modclk), .mux_channel_out(mux),
    .chop_reverse_out(chrev), .inputs_shorted_out(shorted), .sampling_out(samp), .rdy_n_out(rdy_n));
  front_end_model fe (.sampling_in(samp), .reverse_in(chrev), .level_in(level), .result_out(fres));

  // 200 MHz master clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task chk(input string what, input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wreg(input logic [5:0] a, input logic [23:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg

  // read data stands only in the cycle after the strobe
  task rreg(input logic [5:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rreg

  // also notes the modulator clock level during a one-cycle gate
  task wait_samp;
    n = 0;
    while (samp !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1 n++;
      if (n == 1) gate_mod = ~modclk;
    end
    if (n == 4000) n_errors++;
  endtask : wait_samp

  task cnt_samp(input logic lvl);
    n = 0;
    while (samp === lvl && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : cnt_samp

  task wait_rdy;
    n = 0;
    while (rdy_n !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 4000) n_errors++;
  endtask : wait_rdy

  task go(input logic [23:0] mode);
    wreg(6'h00, mode);
    wait_samp;
    wait_rdy;
  endtask : go

  task t_reset;
    chk("rdy pin", 24'(rdy_n), 24'h000001);
    @(posedge mclk);
    #1 b = modclk;
    @(posedge mclk);
    #1 chk("mod clk", 24'(modclk ^ b), 24'h000001);
    rreg(6'h10);
    chk("setup0", rv, 24'h000091);
    rreg(6'h04);
    chk("conv fs", rv, 24'h200000);
    rreg(6'h30);
    chk("ch fs", rv, 24'h200000);
  endtask : t_reset

  task t_single;
    wreg(6'h10, 24'h000000);
    level <= 24'h123456;
    wreg(6'h00, 24'h000001);
    wait_samp;
    chk("settle1", 24'(n == 45 || n == 46), 24'h000001);
    chk("settle1 rule", 24'(n), gate_mod ? 24'd46 : 24'd45);
    cnt_samp(1'b1);
    chk("sample len", 24'(n), 24'd16);
    wait_rdy;
    chk("scale len", 24'(n), 24'd162);
    rreg(6'h01);
    chk("status", rv, 24'h000001);
    rreg(6'h18);
    chk("data", rv, 24'h123456);
    chk("rdy after read", 24'(rdy_n), 24'h000001);
  endtask : t_single

  task t_chop;
    wreg(6'h11, 24'h000181);
    level <= 24'h400000;
    wreg(6'h00, 24'h000009);
    wait_samp;
    cnt_samp(1'b1);
    chk("sample1 len", 24'(n), 24'd32);
    cnt_samp(1'b0);
    chk("settle2", 24'(n), 24'd42);
    chk("reverse", 24'(chrev), 24'h000001);
    cnt_samp(1'b1);
    chk("sample2 len", 24'(n), 24'd32);
    wait_rdy;
    rreg(6'h21);
    chk("chstat1", rv, 24'h000009);
    rreg(6'h19);
    chk("data1", rv, 24'ha00000);
  endtask : t_chop

  task t_range;
    wreg(6'h03, 24'h000010);
    level <= 24'h000000;
    go(24'h000001);
    rreg(6'h20);
    chk("under stat", rv, 24'h000038);
    rreg(6'h18);
    chk("under data", rv, 24'h000000);
    wreg(6'h03, 24'h000000);
    wreg(6'h04, 24'h400000);
    level <= 24'h900000;
    go(24'h000001);
    rreg(6'h20);
    chk("over stat", rv, 24'h000028);
    rreg(6'h18);
    chk("over wrap", rv, 24'h200000);
    go(24'h000041);
    rreg(6'h18);
    chk("clamp", rv, 24'hffffff);
    wreg(6'h04, 24'h200000);
  endtask : t_range

  task t_sync;
    level <= 24'h123456;
    @(posedge mclk);
    sync <= 1'b0;
    wreg(6'h00, 24'h000081);
    n = 0;
    repeat (200) begin
      @(posedge mclk);
      #1 n += samp;
    end
    chk("held", 24'(n), 24'h000000);
    @(posedge mclk);
    sync <= 1'b1;
    wait_samp;
    chk("sync start", 24'(n < 50), 24'h000001);
    wait_rdy;
    @(posedge mclk);
    ref_ok <= 1'b0;
    go(24'h000001);
    ref_ok <= 1'b1;
    rreg(6'h20);
    chk("no ref", rv, 24'h000048);
    rreg(6'h18);
  endtask : t_sync

  task t_cont;
    wreg(6'h02, 24'h000003);
    go(24'h000002);
    wait_samp;
    chk("next chan", 24'(mux), 24'h000001);
    cnt_samp(1'b1);
    chk("own fw", 24'(n), 24'd32);
    chk("rdy stands", 24'(rdy_n), 24'h000000);
    cnt_samp(1'b0);
    cnt_samp(1'b1);
    chk("rdy high", 24'(rdy_n), 24'h000001);
    wait_rdy;
    rreg(6'h01);
    chk("cont status", rv, 24'h000103);
    wreg(6'h00, 24'h000000);
  endtask : t_cont

  task t_cal;
    level <= 24'h000200;
    wreg(6'h00, 24'h000004);
    wait_samp;
    chk("shorted", 24'(shorted), 24'h000001);
    cnt_samp(1'b1);
    chk("cal len", 24'(n), 24'd16);
    wait_rdy;
    rreg(6'h01);
    chk("cal status", rv, 24'h0000ff);
    rreg(6'h03);
    chk("conv zero", rv, 24'h000200);
    rreg(6'h00);
    chk("idle", rv, 24'h000000);
  endtask : t_cal

  // system calibrations after the self calibration, zero before full scale
  task t_syscal;
    level <= 24'h000600;
    go(24'h000006);
    rreg(6'h28);
    chk("ch zero cal", rv, 24'h000400);
    rreg(6'h01);
    chk("sys cal status", rv, 24'h0000ff);
    level <= 24'h400600;
    go(24'h000007);
    rreg(6'h30);
    chk("ch fs cal", rv, 24'h800000);
    level <= 24'h200600;
    go(24'h000001);
    rreg(6'h18);
    chk("calibrated data", rv, 24'h800000);
  endtask : t_syscal

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_single;
    t_chop;
    t_range;
    t_sync;
    t_cont;
    t_cal;
    t_syscal;
    end_of_test;
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end
endmodule : adc_conversion_sequencer_tb
